// *** hdl/kei_consts.vh ***
`ifndef KEI_CONSTS_VH
`define KEI_CONSTS_VH

// Register addresses
`define KEI_ADDR_KEYS_48_TO_55_STATE 8'hE1
`define KEI_ADDR_KEYS_56_TO_63_STATE 8'hE2
`define KEI_ADDR_IRQ_STATUS 8'hE3
`define KEI_ADDR_IRQ_MASK 8'hE4
`define KEI_ADDR_EDGE_SELECT 8'hE8
`define KEI_ADDR_HANDLER_CONTROL 8'hE9

// Event bit positions in status and mask
`define KEI_EV_KEY_PRESSED 0
`define KEI_EV_LONG_KEY 1
`define KEI_EV_TIMEOUT 2
`define KEI_EV_MISSED_KEY 3
`define KEI_EV_COUNT 4

// Edge select: falling enable at 2*event, rising at 2*event+1
`define KEI_EDGE_FALL_OFS 0
`define KEI_EDGE_RISE_OFS 1

// Handler control fields
`define KEI_CTRL_RSVD0_BIT 0
`define KEI_CTRL_PENDING_DISABLE_BIT 1
`define KEI_CTRL_CLEAR_ON_READ_BIT 2

// Reset values
`define KEI_RST_KEYS 8'h00
`define KEI_RST_STATUS 4'h0
`define KEI_RST_MASK 4'hF
`define KEI_RST_EDGE 8'h55
`define KEI_RST_CTRL 3'h1
`define KEI_RST_RDATA 8'h00
`define KEI_RDATA_UNMAPPED 8'h00

`endif

// *** hdl/kei_handler.v ***
// How it works
// - Two read-only key-state registers show a one for every key currently pressed, zero at reset.
// - The register at E1 holds keys 48 to 55 in bits 0 to 7.
// - The register at E2 holds keys 56 to 63 in bits 0 to 7, key 63 on top.
// - Status holds key-pressed, long-key, timeout and missed-key in bits 0 to 3, upper bits zero.
// - Any unmasked status bit at one (missed-key only in test mode) requests service and pulls the active-low interrupt line.
// - Writing ones into status never sets a bit; only hardware events do.
// - In clear-on-read mode writing zero to a status bit leaves it unchanged.
// - The missed-key status bit sets and requests only while test mode is on.
// - A mask bit at one blocks its event from the interrupt; all four reset to one.
// - Per event, edge select 01 catches falling, 10 rising, 11 both, 00 nothing.
// - Edge select bits 7..0 pair rise/fall for missed, timeout, long, key-pressed; falls reset to one.
// - Missed-key edge enables act only in test mode.
// - Pending-disable at one drops events arriving while the interrupt is pending; at zero they are kept.
// - Clear-on-read at one clears status on a read of the status register; at zero bits are cleared by writes.
// - Status and mask update on the register interface clock.
// - Missed-key detection works only while its test enable input is high.
`timescale 1ns/1ps
`include "kei_consts.vh"
`default_nettype none

module kei_handler (
   input wire clk_sys_i, // Register interface clock, 100 MHz
   input wire rst_i, // Asynchronous reset, active high
   input wire [7:0] reg_addr_i, // Register address
   input wire reg_wr_i, // Write strobe, one cycle
   input wire reg_rd_i, // Read strobe, one cycle
   input wire [7:0] reg_wdata_i, // Write data
   output reg [7:0] reg_rdata_o, // Read data, valid the cycle after reg_rd_i
   input wire [15:0] key_state_i, // Keys 48..63 from the scan domain
   input wire key_pressed_event_i, // Scan-domain event level
   input wire long_key_event_i, // Scan-domain event level
   input wire timeout_event_i, // Scan-domain event level
   input wire missed_key_event_i, // Scan-domain event level
   input wire missed_key_test_en_i, // Test mode with miss detection enabled
   output reg keypad_irq_out_low_n_o // Interrupt to host, active low
);

   // Edge hit for one event from its level history and two enables
   function edge_hit;
      input cur;
      input prev;
      input rise_en;
      input fall_en;
      begin
         edge_hit = (rise_en & cur & ~prev) | (fall_en & ~cur & prev);
      end
   endfunction

   // Debounced update: take the new level only once stages two and three agree
   function [19:0] agree;
      input [19:0] s2;
      input [19:0] s3;
      input [19:0] held;
      begin
         agree = (s2 & s3) | (held & (s2 | s3));
      end
   endfunction

   reg [19:0] sync1_q;
   reg [19:0] sync2_q;
   reg [19:0] sync3_q;
   reg [19:0] held_q;
   wire [19:0] held_d;
   reg [3:0] ev_prev_q;
   reg [3:0] status_q;
   reg [3:0] status_d;
   reg [3:0] mask_q;
   reg [7:0] edge_q;
   reg [2:0] ctrl_q;
   reg [3:0] hit;
   reg [3:0] clr;
   reg [3:0] gate;
   reg [7:0] rdata_d;
   wire [3:0] ev_now;
   wire irq_active;
   wire clear_on_read_select;
   wire pending_event_disable;
   wire sel_status;

   assign held_d = agree(sync2_q, sync3_q, held_q);
   assign ev_now = held_q[19:16];
   assign clear_on_read_select = ctrl_q[`KEI_CTRL_CLEAR_ON_READ_BIT];
   assign pending_event_disable = ctrl_q[`KEI_CTRL_PENDING_DISABLE_BIT];
   assign sel_status = (reg_addr_i == `KEI_ADDR_IRQ_STATUS);
   wire key_pressed_status;
   wire long_key_status;
   wire timeout_status;
   wire missed_key_status;
   wire key_pressed_mask;
   wire long_key_mask;
   wire timeout_mask;
   wire missed_key_mask;
   wire wr_mask;
   wire wr_edge;
   wire wr_ctrl;

   assign key_pressed_status = status_q[`KEI_EV_KEY_PRESSED];
   assign long_key_status = status_q[`KEI_EV_LONG_KEY];
   assign timeout_status = status_q[`KEI_EV_TIMEOUT];
   assign missed_key_status = status_q[`KEI_EV_MISSED_KEY];
   assign key_pressed_mask = mask_q[`KEI_EV_KEY_PRESSED];
   assign long_key_mask = mask_q[`KEI_EV_LONG_KEY];
   assign timeout_mask = mask_q[`KEI_EV_TIMEOUT];
   assign missed_key_mask = mask_q[`KEI_EV_MISSED_KEY];

   // Writes to the key-state and unmapped addresses fall through unused
   assign wr_mask = reg_wr_i && (reg_addr_i == `KEI_ADDR_IRQ_MASK);
   assign wr_edge = reg_wr_i && (reg_addr_i == `KEI_ADDR_EDGE_SELECT);
   assign wr_ctrl = reg_wr_i && (reg_addr_i == `KEI_ADDR_HANDLER_CONTROL);

   // Missed-key only counts toward the line in test mode
   assign irq_active = (key_pressed_status & ~key_pressed_mask)
                       | (long_key_status & ~long_key_mask)
                       | (timeout_status & ~timeout_mask)
                       | (missed_key_status & ~missed_key_mask & gate[`KEI_EV_MISSED_KEY]);

   // Scan-domain inputs cross on three flops
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_q <= 20'h00000;
         sync2_q <= 20'h00000;
         sync3_q <= 20'h00000;
      end else begin
         sync1_q <= {missed_key_event_i, timeout_event_i, long_key_event_i,
                     key_pressed_event_i, key_state_i};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // Committed levels; a one-cycle glitch never reaches them
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         held_q <= 20'h00000;
      end else begin
         held_q <= held_d;
      end
   end

   // Resets to the idle low level, so no false edge follows reset
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ev_prev_q <= 4'h0;
      end else begin
         ev_prev_q <= ev_now;
      end
   end

   wire key_pressed_rise_en;
   wire key_pressed_fall_en;
   wire long_key_rise_en;
   wire long_key_fall_en;
   wire timeout_rise_en;
   wire timeout_fall_en;
   wire missed_key_rise_en;
   wire missed_key_fall_en;
   wire key_pressed_hit;
   wire long_key_hit;
   wire timeout_hit;
   wire missed_key_hit;

   // Falling enable at bit 2*event, rising one above it
   assign key_pressed_rise_en = edge_q[2 * `KEI_EV_KEY_PRESSED + `KEI_EDGE_RISE_OFS];
   assign key_pressed_fall_en = edge_q[2 * `KEI_EV_KEY_PRESSED + `KEI_EDGE_FALL_OFS];
   assign long_key_rise_en = edge_q[2 * `KEI_EV_LONG_KEY + `KEI_EDGE_RISE_OFS];
   assign long_key_fall_en = edge_q[2 * `KEI_EV_LONG_KEY + `KEI_EDGE_FALL_OFS];
   assign timeout_rise_en = edge_q[2 * `KEI_EV_TIMEOUT + `KEI_EDGE_RISE_OFS];
   assign timeout_fall_en = edge_q[2 * `KEI_EV_TIMEOUT + `KEI_EDGE_FALL_OFS];
   assign missed_key_rise_en = edge_q[2 * `KEI_EV_MISSED_KEY + `KEI_EDGE_RISE_OFS];
   assign missed_key_fall_en = edge_q[2 * `KEI_EV_MISSED_KEY + `KEI_EDGE_FALL_OFS];

   // Each event sees its own edge pair on the committed level
   assign key_pressed_hit = edge_hit(ev_now[`KEI_EV_KEY_PRESSED],
                                     ev_prev_q[`KEI_EV_KEY_PRESSED],
                                     key_pressed_rise_en, key_pressed_fall_en);
   assign long_key_hit = edge_hit(ev_now[`KEI_EV_LONG_KEY],
                                  ev_prev_q[`KEI_EV_LONG_KEY],
                                  long_key_rise_en, long_key_fall_en);
   assign timeout_hit = edge_hit(ev_now[`KEI_EV_TIMEOUT],
                                 ev_prev_q[`KEI_EV_TIMEOUT],
                                 timeout_rise_en, timeout_fall_en);
   assign missed_key_hit = edge_hit(ev_now[`KEI_EV_MISSED_KEY],
                                    ev_prev_q[`KEI_EV_MISSED_KEY],
                                    missed_key_rise_en, missed_key_fall_en);

   always @* begin
      gate = 4'hF;
      gate[`KEI_EV_MISSED_KEY] = missed_key_test_en_i;
   end

   always @* begin
      hit = 4'h0;
      hit[`KEI_EV_KEY_PRESSED] = key_pressed_hit;
      hit[`KEI_EV_LONG_KEY] = long_key_hit;
      hit[`KEI_EV_TIMEOUT] = timeout_hit;
      hit[`KEI_EV_MISSED_KEY] = missed_key_hit;
      hit = hit & gate;
      // Latency window: with pending_event_disable set, while an unmasked status bit is set (irq_active), new events are dropped
      if (pending_event_disable && irq_active) begin
         hit = 4'h0;
      end
   end

   // Status writes are ignored altogether in clear-on-read mode
   always @* begin
      clr = 4'h0;
      if (clear_on_read_select) begin
         if (reg_rd_i && sel_status) begin
            clr = 4'hF;
         end
      end else if (reg_wr_i && sel_status) begin
         clr = reg_wdata_i[3:0];
      end
   end

   // Set wins over clear; writes only ever clear
   always @* begin
      status_d = (status_q & ~clr) | hit;
   end

   always @* begin
      case (reg_addr_i)
         `KEI_ADDR_KEYS_48_TO_55_STATE: rdata_d = held_q[7:0];
         `KEI_ADDR_KEYS_56_TO_63_STATE: rdata_d = held_q[15:8];
         `KEI_ADDR_IRQ_STATUS: begin
            rdata_d = {4'h0, missed_key_status, timeout_status, long_key_status,
                       key_pressed_status};
         end
         `KEI_ADDR_IRQ_MASK: rdata_d = {4'h0, mask_q};
         `KEI_ADDR_EDGE_SELECT: rdata_d = edge_q;
         `KEI_ADDR_HANDLER_CONTROL: rdata_d = {5'h00, ctrl_q};
         default: rdata_d = `KEI_RDATA_UNMAPPED;
      endcase
   end

   // Status, mask and controls all live on the interface clock
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         status_q <= `KEI_RST_STATUS;
      end else begin
         status_q <= status_d;
      end
   end

   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         mask_q <= `KEI_RST_MASK;
      end else if (wr_mask) begin
         mask_q <= reg_wdata_i[3:0];
      end
   end

   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         edge_q <= `KEI_RST_EDGE;
      end else if (wr_edge) begin
         edge_q <= reg_wdata_i;
      end
   end

   // Reserved bit 0 is stored as written; bits 7..3 are dropped
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= `KEI_RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata_i[2:0];
      end
   end

   // Read data holds until the next read strobe
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= `KEI_RST_RDATA;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end
   end

   // Registered so the line never glitches while status settles
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         keypad_irq_out_low_n_o <= 1'b1;
      end else begin
         keypad_irq_out_low_n_o <= ~irq_active;
      end
   end

endmodule

`default_nettype wire

// *** tb/kei_handler_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module kei_handler_chk (
   input wire logic clk_sys_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic [7:0] reg_addr_i, // Address
   input wire logic reg_rd_i, // Read strobe
   input wire logic [7:0] reg_rdata_o, // Read data
   input wire logic [15:0] key_state_i, // Keys
   input wire logic keypad_irq_out_low_n_o // Irq
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_stat_upper: assert property (reg_rd_i && reg_addr_i == 8'hE3
      |=> reg_rdata_o[7:4] == 4'h0) else $error("status upper bits");
   a_mask_upper: assert property (reg_rd_i && reg_addr_i == 8'hE4
      |=> reg_rdata_o[7:4] == 4'h0) else $error("mask upper bits");
   a_ctrl_upper: assert property (reg_rd_i && reg_addr_i == 8'hE9
      |=> reg_rdata_o[7:3] == 5'h00) else $error("control upper bits");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i < 8'hE1
      |=> reg_rdata_o == 8'h00) else $error("unmapped read");
   a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
   a_keys_low: assert property (($stable(key_state_i))[*7] ##0 reg_rd_i && reg_addr_i == 8'hE1
      |=> reg_rdata_o == $past(key_state_i[7:0])) else $error("keys low");
   a_keys_high: assert property (($stable(key_state_i))[*7] ##0 reg_rd_i && reg_addr_i == 8'hE2
      |=> reg_rdata_o == $past(key_state_i[15:8])) else $error("keys high");
   a_irq_quiet: assert property ($fell(rst_i) |-> keypad_irq_out_low_n_o[*3])
      else $error("irq after reset");
endmodule
`default_nettype wire

// *** tb/kei_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module kei_host (
   input wire logic clk_sys_i, // Clock
   output logic [7:0] reg_addr_o = 8'h00, // Address
   output logic reg_wr_o = 1'b0, // Write strobe
   output logic reg_rd_o = 1'b0, // Read strobe
   output logic [7:0] reg_wdata_o = 8'h00, // Write data
   input wire logic [7:0] reg_rdata_i // Read data
);
   // Strobes last one cycle, so one register access per call
   task wr(input logic [7:0] a, d);
      @(negedge clk_sys_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge clk_sys_i);
      reg_wr_o = 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clk_sys_i);
      reg_rd_o = 1'b0;
      d = reg_rdata_i;
   endtask
endmodule
`default_nettype wire

// *** tb/tb_kei_handler.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_kei_handler;
   logic clk_sys_i = 0;
   logic rst_i = 1;
   logic [15:0] keys = 16'h0000;
   logic [3:0] ev = 4'h0;
   logic tst = 0;
   logic [7:0] a, wd, rdat, d;
   logic wr, rd, irq_n;
   int err_count = 0, n_checks = 0, cyc = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (++cyc == 2000) begin
      err_count++;
      results;
   end
   kei_host u_kei_host (.clk_sys_i(clk_sys_i), .reg_addr_o(a), .reg_wr_o(wr), .reg_rd_o(rd),
      .reg_wdata_o(wd), .reg_rdata_i(rdat));
   kei_handler u_kei_handler (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(a),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat), .key_state_i(keys),
      .key_pressed_event_i(ev[0]), .long_key_event_i(ev[1]), .timeout_event_i(ev[2]),
      .missed_key_event_i(ev[3]), .missed_key_test_en_i(tst), .keypad_irq_out_low_n_o(irq_n));
   task chk(input logic [7:0] g, e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task r(input logic [7:0] ad, e);
      u_kei_host.rd(ad, d);
      chk(d, e);
   endtask
   task w(input logic [7:0] ad, v);
      u_kei_host.wr(ad, v);
   endtask
   // Pulse long enough to pass the input synchronisers
   task pulse(input int i);
      ev[i] = 1;
      repeat (6) @(negedge clk_sys_i);
      ev[i] = 0;
      repeat (8) @(negedge clk_sys_i);
   endtask
   task t_reset;
      r(8'hE2, 8'h00);
      r(8'hE3, 8'h00);
      r(8'hE4, 8'h0F);
      r(8'hE8, 8'h55);
      r(8'hE9, 8'h01);
      r(8'h5A, 8'h00);
   endtask
   task t_keys;
      keys = 16'h8001;
      repeat (6) @(negedge clk_sys_i);
      w(8'hE1, 8'hFF);
      r(8'hE1, 8'h01);
      r(8'hE2, 8'h80);
   endtask
   task t_edge;
      w(8'hE4, 8'h0E);
      w(8'hE8, 8'h02);
      pulse(0);
      r(8'hE3, 8'h01);
      chk({7'h00, irq_n}, 8'h00);
      w(8'hE3, 8'h01);
      r(8'hE3, 8'h00);
      chk({7'h00, irq_n}, 8'h01);
      pulse(1);
      r(8'hE3, 8'h00);
      w(8'hE8, 8'h0C);
      pulse(1);
      r(8'hE3, 8'h02);
      chk({7'h00, irq_n}, 8'h01);
      w(8'hE3, 8'hFF);
      r(8'hE3, 8'h00);
   endtask
   task t_cor;
      w(8'hE9, 8'h04);
      w(8'hE8, 8'h30);
      pulse(2);
      w(8'hE3, 8'h00);
      r(8'hE3, 8'h04);
      r(8'hE3, 8'h00);
      w(8'hE8, 8'hC0);
      w(8'hE4, 8'h07);
      pulse(3);
      r(8'hE3, 8'h00);
      tst = 1;
      pulse(3);
      chk({7'h00, irq_n}, 8'h00);
      r(8'hE3, 8'h08);
      tst = 0;
   endtask
   task t_pend;
      w(8'hE9, 8'h02);
      w(8'hE4, 8'h00);
      w(8'hE8, 8'h0F);
      pulse(0);
      pulse(1);
      r(8'hE3, 8'h01);
      w(8'hE3, 8'h01);
      w(8'hE9, 8'h00);
      pulse(0);
      pulse(1);
      r(8'hE3, 8'h03);
   endtask
   task results;
      if (err_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge clk_sys_i);
      rst_i = 0;
      t_reset;
      t_keys;
      t_edge;
      t_cor;
      t_pend;
      results;
   end
endmodule
bind kei_handler kei_handler_chk u_kei_handler_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .key_state_i(key_state_i), .keypad_irq_out_low_n_o(keypad_irq_out_low_n_o));
`default_nettype wire
